// >>> src/sram_port_map.vh
// Constants for the synchronous burst static memory port.
// Assumes inclusion by bare name from the port's design files.
`ifndef SRAM_PORT_MAP_VH
`define SRAM_PORT_MAP_VH

// ----------------------------------------------------------------
// Organisation defaults
// ----------------------------------------------------------------
`define SP_ADDR_W 19
`define SP_LANES 4
`define SP_LANE_W 9
`define SP_BURST_W 2

// ----------------------------------------------------------------
// Access state, one-hot
// ----------------------------------------------------------------
`define SP_ST_W 3
`define SP_ST_DESEL 3'h1
`define SP_ST_READ 3'h2
`define SP_ST_WRITE 3'h4

// ----------------------------------------------------------------
// Burst order select levels
// ----------------------------------------------------------------
`define SP_ORDER_LINEAR 1'b0
`define SP_ORDER_INTERLEAVE 1'b1

`endif

// >>> src/burst_addr_step.v
// Low two address bits of one burst beat from the start bits and beat count.
// Assumes the caller holds the start bits for the whole burst.
`timescale 1ns/100ps
`include "sram_port_map.vh"

module burst_addr_step (
  input wire [`SP_BURST_W-1:0] start_lsb,
  input wire [`SP_BURST_W-1:0] beat,
  input wire order_sel,
  output reg [`SP_BURST_W-1:0] beat_lsb
);

  // ----------------------------------------------------------------
  // Linear adds, interleaved flips; both wrap in two bits
  // ----------------------------------------------------------------
  always @* begin
    if (order_sel == `SP_ORDER_LINEAR) begin
      beat_lsb = start_lsb + beat;
    end else begin
      beat_lsb = start_lsb ^ beat;
    end
  end

endmodule

// >>> src/sync_burst_sram_port.v
// Memory side of a synchronous no-turnaround burst static memory port.
// Assumes bus inputs are synchronous to ref_clk; snooze, output enable and
// burst order select are asynchronous and are synchronised here.
`timescale 1ns/100ps
`include "sram_port_map.vh"

module sync_burst_sram_port #(
  parameter ADDR_W = `SP_ADDR_W,
  parameter LANES = `SP_LANES,
  parameter LANE_W = `SP_LANE_W
) (
  input wire ref_clk,
  input wire rstn,
  input wire [ADDR_W-3:0] upper_address,
  input wire addr_bit_0,
  input wire addr_bit_1,
  input wire load_or_advance_n,
  input wire read_write_n,
  input wire chip_select_a_n,
  input wire chip_select_b_n,
  input wire chip_select_c_high,
  input wire lane0_write_en_n,
  input wire lane1_write_en_n,
  input wire lane2_write_en_n,
  input wire lane3_write_en_n,
  input wire clock_enable_n,
  input wire output_enable_n,
  input wire burst_order_select,
  input wire snooze_request,
  input wire [LANES*LANE_W-1:0] data_lanes_in,
  output reg [LANES*LANE_W-1:0] data_lanes_out,
  output reg data_lanes_oe
);

  // ----------------------------------------------------------------
  // Asynchronous inputs, two flip-flops each
  // ----------------------------------------------------------------
  reg snz_m_q;
  reg snz_s_q;
  reg oe_m_q;
  reg oe_s_q;
  reg ord_m_q;
  reg ord_s_q;

  // Reset values: snooze off, outputs disabled, interleaved order
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      snz_m_q <= 1'b0;
      snz_s_q <= 1'b0;
      oe_m_q <= 1'b1;
      oe_s_q <= 1'b1;
      ord_m_q <= `SP_ORDER_INTERLEAVE;
      ord_s_q <= `SP_ORDER_INTERLEAVE;
    end else begin
      snz_m_q <= snooze_request;
      snz_s_q <= snz_m_q;
      oe_m_q <= output_enable_n;
      oe_s_q <= oe_m_q;
      ord_m_q <= burst_order_select;
      ord_s_q <= ord_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Cycle qualification
  // ----------------------------------------------------------------
  // Snooze and a high clock enable both freeze the pipeline outright
  wire run = ~clock_enable_n & ~snz_s_q;
  wire load = ~load_or_advance_n;
  wire selected = ~chip_select_a_n & ~chip_select_b_n & chip_select_c_high;

  wire [3:0] bw_pins = {lane3_write_en_n, lane2_write_en_n, lane1_write_en_n,
    lane0_write_en_n};
  // Only the low LANES enables exist in a narrow organisation
  wire [LANES-1:0] lane_we = ~bw_pins[LANES-1:0];

  // ----------------------------------------------------------------
  // Access state and burst counter
  // ----------------------------------------------------------------
  localparam ST_DESEL = `SP_ST_DESEL;
  localparam ST_READ = `SP_ST_READ;
  localparam ST_WRITE = `SP_ST_WRITE;

  reg [`SP_ST_W-1:0] state_q;
  reg [`SP_ST_W-1:0] state_d;
  reg [ADDR_W-3:0] upper_q;
  reg [`SP_BURST_W-1:0] start_q;
  reg [`SP_BURST_W-1:0] beat_q;
  wire [`SP_BURST_W-1:0] step_lsb;
  wire [`SP_BURST_W-1:0] next_beat = beat_q + 2'h1;

  burst_addr_step u_step (
    .start_lsb(start_q),
    .beat(next_beat),
    .order_sel(ord_s_q),
    .beat_lsb(step_lsb)
  );

  always @* begin
    state_d = state_q;
    if (load) begin
      if (!selected) begin
        state_d = ST_DESEL;
      end else if (read_write_n) begin
        state_d = ST_READ;
      end else begin
        state_d = ST_WRITE;
      end
    end
    // Advance keeps the current type, deselect included
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_DESEL;
      upper_q <= {(ADDR_W-2){1'b0}};
      start_q <= 2'h0;
      beat_q <= 2'h0;
    end else if (run) begin
      state_q <= state_d;
      if (load) begin
        upper_q <= upper_address;
        start_q <= {addr_bit_1, addr_bit_0};
        beat_q <= 2'h0;
      end else begin
        beat_q <= next_beat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pipeline: stage one holds the decoded beat, stage two meets data
  // ----------------------------------------------------------------
  reg s1_v_q;
  reg s1_wr_q;
  reg [ADDR_W-1:0] s1_addr_q;
  reg [LANES-1:0] s1_we_q;
  reg s2_v_q;
  reg s2_wr_q;
  reg [ADDR_W-1:0] s2_addr_q;
  reg [LANES-1:0] s2_we_q;
  reg rd_live_q;

  wire [ADDR_W-1:0] beat_addr = load ? {upper_address, addr_bit_1, addr_bit_0} :
    {upper_q, step_lsb};

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_v_q <= 1'b0;
      s1_wr_q <= 1'b0;
      s1_addr_q <= {ADDR_W{1'b0}};
      s1_we_q <= {LANES{1'b0}};
      s2_v_q <= 1'b0;
      s2_wr_q <= 1'b0;
      s2_addr_q <= {ADDR_W{1'b0}};
      s2_we_q <= {LANES{1'b0}};
      rd_live_q <= 1'b0;
    end else if (run) begin
      s1_v_q <= state_d != ST_DESEL;
      s1_wr_q <= state_d == ST_WRITE;
      s1_addr_q <= beat_addr;
      s1_we_q <= lane_we;
      s2_v_q <= s1_v_q;
      s2_wr_q <= s1_wr_q;
      s2_addr_q <= s1_addr_q;
      s2_we_q <= s1_we_q;
      rd_live_q <= s2_v_q & ~s2_wr_q;
    end
  end

  // ----------------------------------------------------------------
  // Array; no reset, contents survive snooze and stalls
  // ----------------------------------------------------------------
  // One array per lane, so each lane's write port has a single driver
  wire do_write = run & s2_v_q & s2_wr_q;
  wire [LANES*LANE_W-1:0] rd_word;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      reg [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
      always @(posedge ref_clk) begin
        if (do_write && s2_we_q[g]) begin
          lane_mem[s2_addr_q] <= data_lanes_in[g*LANE_W +: LANE_W];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[s2_addr_q];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data and driver enable
  // ----------------------------------------------------------------
  // Output enable is synchronised, so it gates the drivers three edges late
  wire rd_next = run ? (s2_v_q & ~s2_wr_q) : rd_live_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_lanes_out <= {(LANES*LANE_W){1'b0}};
      data_lanes_oe <= 1'b0;
    end else begin
      if (run && s2_v_q && !s2_wr_q) begin
        data_lanes_out <= rd_word;
      end
      data_lanes_oe <= rd_next & ~oe_s_q & ~snz_s_q;
    end
  end

endmodule

// >>> tb/bus_ctrl_model.sv
// Controller side of the shared data bus.
// Assumes the bench says when to drive write data.
`timescale 1ns/100ps
module bus_ctrl_model (
  input wire ref_clk,
  input wire drv,
  input wire [35:0] wd,
  input wire dev_oe,
  input wire [35:0] dev_out,
  output logic [35:0] bus
);
  logic [35:0] last_q = 36'h0;
  always @(posedge ref_clk) last_q <= bus;
  // Released bus flips each cycle so stale data never looks valid
  always_comb bus = dev_oe ? dev_out : (drv ? wd : ~last_q);
endmodule

// >>> tb/sram_port_props.sv
// Port checks for the burst memory port.
// Assumes a bind onto every instance of the port.
`timescale 1ns/100ps
module sram_port_props #(parameter W = 36) (
  input wire ref_clk,
  input wire rstn,
  input wire load_or_advance_n,
  input wire read_write_n,
  input wire chip_select_a_n,
  input wire chip_select_b_n,
  input wire chip_select_c_high,
  input wire clock_enable_n,
  input wire output_enable_n,
  input wire snooze_request,
  input wire [W-1:0] data_lanes_out,
  input wire data_lanes_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire act = !clock_enable_n && !snooze_request;
  wire sel = !chip_select_a_n && !chip_select_b_n && chip_select_c_high;
  wire ld = !load_or_advance_n && sel && act;
  sequence rd_ok;
    (!output_enable_n && !snooze_request)[*3] ##0 (ld && read_write_n);
  endsequence
  stall_hold_a: assert property (clock_enable_n |=> $stable(data_lanes_out))
    else $error("read data moved on a stall edge");
  desel_quiet_a: assert property (!load_or_advance_n && !sel && act
    ##1 (act && load_or_advance_n)[*3] |=> !data_lanes_oe) else $error("driving when idle");
  write_quiet_a: assert property (ld && !read_write_n
    ##1 (act && load_or_advance_n)[*3] |=> !data_lanes_oe) else $error("driving in a write");
  read_drive_a: assert property (rd_ok ##1 (act && !output_enable_n)[*2] |=> data_lanes_oe)
    else $error("read data not driven");
  read_keep_a: assert property (rd_ok ##1 (act && load_or_advance_n && !output_enable_n)
    ##1 (act && !output_enable_n) ##1 (act && load_or_advance_n && !output_enable_n)
    |=> data_lanes_oe) else $error("read burst lost drive");
  oe_gate_a: assert property (output_enable_n[*5] |-> !data_lanes_oe)
    else $error("drivers on with output enable off");
  snooze_off_a: assert property (snooze_request[*5] |-> !data_lanes_oe)
    else $error("drivers on in snooze");
  snooze_hold_a: assert property (snooze_request[*4] |=> $stable(data_lanes_out))
    else $error("read data moved in snooze");
  cover property (rd_ok ##1 clock_enable_n);
  cover property (snooze_request[*5]);
  cover property (!load_or_advance_n && !sel ##1 load_or_advance_n);
endmodule
bind sync_burst_sram_port sram_port_props #(.W(LANES*LANE_W)) sram_port_props_inst (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .load_or_advance_n(load_or_advance_n),
  .read_write_n(read_write_n),
  .chip_select_a_n(chip_select_a_n),
  .chip_select_b_n(chip_select_b_n),
  .chip_select_c_high(chip_select_c_high),
  .clock_enable_n(clock_enable_n),
  .output_enable_n(output_enable_n),
  .snooze_request(snooze_request),
  .data_lanes_out(data_lanes_out),
  .data_lanes_oe(data_lanes_oe)
);

// >>> tb/sync_burst_sram_port_bench.sv
// Bench for the burst memory port: bursts, stall, deselect, snooze.
// Assumes the port, the bus model and the checker are compiled first.
`timescale 1ns/100ps
module sync_burst_sram_port_bench;
  logic ref_clk = 0, rstn = 0, load_or_advance_n = 1, read_write_n = 1, drv = 0;
  logic chip_select_a_n = 1, chip_select_b_n = 0, chip_select_c_high = 1;
  logic clock_enable_n = 0, output_enable_n = 0, burst_order_select = 0, snooze_request = 0;
  logic [3:0] upper_address = 4'h0, be_n = 4'h0;
  logic [1:0] lo = 2'h0;
  logic [35:0] wd = 36'h0, bus, dout, mem [0:63];
  logic oe;
  integer n_mismatch = 0, tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  sync_burst_sram_port #(.ADDR_W(6)) sync_burst_sram_port_inst (.ref_clk(ref_clk),
    .rstn(rstn), .upper_address(upper_address), .addr_bit_0(lo[0]), .addr_bit_1(lo[1]),
    .load_or_advance_n(load_or_advance_n), .read_write_n(read_write_n),
    .chip_select_a_n(chip_select_a_n), .chip_select_b_n(chip_select_b_n),
    .chip_select_c_high(chip_select_c_high), .lane0_write_en_n(be_n[0]),
    .lane1_write_en_n(be_n[1]), .lane2_write_en_n(be_n[2]), .lane3_write_en_n(be_n[3]),
    .clock_enable_n(clock_enable_n), .output_enable_n(output_enable_n),
    .burst_order_select(burst_order_select), .snooze_request(snooze_request),
    .data_lanes_in(bus), .data_lanes_out(dout), .data_lanes_oe(oe));
  bus_ctrl_model bus_ctrl_model_inst (.ref_clk(ref_clk), .drv(drv), .wd(wd), .dev_oe(oe),
    .dev_out(dout), .bus(bus));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task check(input [35:0] seen, input [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Load, three advances, two idle loads; beat data lags its address by two edges
  task burst(input rd, input [5:0] a, input [3:0] pm, input stall);
    integer n, k;
    logic [5:0] b;
    for (n = 0; n < 6; n++) begin
      load_or_advance_n = n > 0 && n < 4;
      chip_select_a_n = n > 3;
      chip_select_c_high = n == 0;
      read_write_n = (n == 0) ? rd : !rd;
      {upper_address, lo} = (n == 0) ? a : 6'h0;
      be_n = (n == 1) ? pm : 4'h0;
      b = {a[5:2], burst_order_select ? a[1:0] ^ 2'(n - 2) : a[1:0] + 2'(n - 2)};
      drv = !rd && n > 1;
      wd = {a, 6'(n), 24'h5a_c3e1};
      for (k = 0; k < 4; k++)
        if (drv && !(n == 3 && pm[k])) mem[b][k*9 +: 9] = wd[k*9 +: 9];
      if (stall && n == 3) begin
        clock_enable_n = 1;
        tick;
        check(dout, mem[a]);
        clock_enable_n = 0;
      end
      tick;
      if (rd && n > 1) begin
        check(dout, mem[b]);
        check(oe, !output_enable_n);
      end
    end
    drv = 0;
  endtask
  task desel;
    chip_select_a_n = 0;
    chip_select_b_n = 1;
    chip_select_c_high = 1;
    read_write_n = 1;
    load_or_advance_n = 0;
    tick;
    // A selected read encoding on advance edges must not leave deselect
    chip_select_b_n = 0;
    load_or_advance_n = 1;
    repeat (3) tick;
    check(oe, 1'b0);
    $display("test deselect done");
  endtask
  // A read load in snooze would drive the bus, a write load would corrupt the readback
  task snooze;
    snooze_request = 1;
    repeat (3) tick;
    {upper_address, lo} = 6'h05;
    {chip_select_a_n, load_or_advance_n} = 2'h0;
    read_write_n = 1;
    repeat (2) tick;
    read_write_n = 0;
    repeat (2) tick;
    check(oe, 1'b0);
    chip_select_a_n = 1;
    snooze_request = 0;
    repeat (3) tick;
    burst(1, 6'h05, 4'h0, 0);
    $display("test snooze done");
  endtask
  task linear;
    burst(0, 6'h05, 4'h0, 0);
    burst(0, 6'h05, 4'ha, 0);
    burst(1, 6'h05, 4'h0, 1);
    $display("test linear done");
  endtask
  task interleave;
    burst_order_select = 1;
    repeat (3) tick;
    burst(0, 6'h2a, 4'h0, 0);
    burst(1, 6'h2a, 4'h0, 0);
    $display("test interleave done");
  endtask
  // Output enable off: reads still refresh the data register, drivers stay off
  task out_gate;
    output_enable_n = 1;
    repeat (2) tick;
    burst(1, 6'h2a, 4'h0, 0);
    output_enable_n = 0;
    $display("test output gate done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1;
    // Order select synchroniser resets to interleaved; let it settle first
    repeat (2) tick;
    linear;
    interleave;
    out_gate;
    desel;
    snooze;
    end_of_test;
  end
  initial begin
    #(400 * 50);
    n_mismatch++;
    end_of_test;
  end
endmodule
